// [hdl/jtap_tap_ctrl.sv]
// boundary-scan tap controller: state machine, ir, data registers, tdo
//
// Function
// [R01] sixteen-state machine advances on each tck rise using sampled tms
// [R02] five tms-high rises reach test-logic-reset; stays there while tms high
// [R03] in test-logic-reset test logic off, instruction forced to idcode
// [R04] reset enters test-logic-reset without any tck or tms activity
// [R05] idle holds while tms low; tms high goes to select-dr
// [R06] select-dr goes to capture-dr on low, select-ir on high
// [R07] capture-dr loads boundary register from pins for extest or sample
// [R08] capture-dr goes to exit1-dr on high, shift-dr on low
// [R09] shift-dr shifts selected register toward tdo each rise
// [R10] exit1-dr goes to update-dr on high, pause-dr on low
// [R11] pause-dr halts shifting, holds; tms high goes to exit2-dr
// [R12] exit2-dr goes to update-dr on high, shift-dr on low
// [R13] boundary parallel output loads only in update-dr on tck fall
// [R14] select-ir goes to capture-ir on low, test-logic-reset on high
// [R15] capture-ir loads fixed pattern 100 into instruction shifter
// [R16] capture-ir goes to exit1-ir on high, shift-ir on low
// [R17] shift-ir shifts instruction register toward tdo each rise
// [R18] instruction changes only in update-ir or test-logic-reset; other registers hold
// [R19] exit1-ir goes to update-ir on high, pause-ir on low
// [R20] pause-ir halts instruction shifting; tms high goes to exit2-ir
// [R21] exit2-ir goes to update-ir on high, shift-ir on low
// [R22] update-ir latches shifted instruction on tck fall
// [R23] update states go to select-dr on high, idle on low
// [R24] tdo driven only in shift states, changing on tck fall
`timescale 1ns/10ps
module jtap_tap_ctrl
   import jtap_pkg::*;
#(
   parameter int                 BSR_LEN  = BSR_LEN_DEF,
   parameter logic [ID_LEN-1:0]  ID_VALUE = ID_DEFAULT
) (
   input  wire logic               clk,
   input  wire logic               srst,
   input  wire logic               tck,
   input  wire logic               tms,
   input  wire logic               tdi,
   input  wire logic [BSR_LEN-1:0] pin_in,
   output logic                    tdo,
   output logic                    tdo_oe,
   output logic      [BSR_LEN-1:0] bsr_out,
   output logic                    extest_drive,
   output logic                    test_reset,
   output logic      [3:0]         tap_state,
   output logic      [IR_LEN-1:0]  cur_instr
);

   // all controller state in one record
   // tck_d is the last synchronised tck, kept for edge detection
   typedef struct packed {
      jtap_state_e state;
      logic        tck_d;
      logic        bypass;
      logic        tdo;
      logic        tdo_oe;
      logic        extest;
   } jtap_ctrl_s;

   jtap_ctrl_s st_ff;
   jtap_ctrl_s nxt_st;

   // synchronised pins
   logic [2:0]         pins_s;
   logic               tck_s;
   logic               tms_s;
   logic               tdi_s;

   // tck edge strobes, one clk cycle each
   logic               tck_rise;
   logic               tck_fall;

   // state decodes
   logic               in_tlr;
   logic               in_cap_dr;
   logic               in_sh_dr;
   logic               in_upd_dr;
   logic               in_cap_ir;
   logic               in_sh_ir;
   logic               in_upd_ir;

   // data register selection from the current instruction
   logic               sel_bsr;
   logic               sel_id;
   logic               sel_byp;

   // register outputs
   logic [IR_LEN-1:0]  ir_sreg;
   logic [IR_LEN-1:0]  ir_preg;
   logic [BSR_LEN-1:0] bsr_sreg;
   logic [ID_LEN-1:0]  id_sreg;
   logic               scan_out;

   // next-state function of the controller
   function automatic jtap_state_e tap_next(input jtap_state_e cur,
                                            input logic        tms_v);
      jtap_state_e nxt;
      nxt = cur;
      case (cur)
         // [R02] tms high holds reset
         ST_TLR: begin
            nxt = tms_v ? ST_TLR : ST_IDLE;
         end
         // [R05] idle hold or leave
         ST_IDLE: begin
            nxt = tms_v ? ST_SEL_DR : ST_IDLE;
         end
         // [R06] select-dr branch
         ST_SEL_DR: begin
            nxt = tms_v ? ST_SEL_IR : ST_CAP_DR;
         end
         // [R08] capture-dr exit
         ST_CAP_DR: begin
            nxt = tms_v ? ST_EX1_DR : ST_SH_DR;
         end
         // [R09] shift-dr loop
         ST_SH_DR: begin
            nxt = tms_v ? ST_EX1_DR : ST_SH_DR;
         end
         // [R10] exit1-dr branch
         ST_EX1_DR: begin
            nxt = tms_v ? ST_UPD_DR : ST_PAU_DR;
         end
         // [R11] pause-dr hold
         ST_PAU_DR: begin
            nxt = tms_v ? ST_EX2_DR : ST_PAU_DR;
         end
         // [R12] exit2-dr branch
         ST_EX2_DR: begin
            nxt = tms_v ? ST_UPD_DR : ST_SH_DR;
         end
         // [R23] update-dr exit
         ST_UPD_DR: begin
            nxt = tms_v ? ST_SEL_DR : ST_IDLE;
         end
         // [R14] select-ir branch
         ST_SEL_IR: begin
            nxt = tms_v ? ST_TLR : ST_CAP_IR;
         end
         // [R16] capture-ir exit
         ST_CAP_IR: begin
            nxt = tms_v ? ST_EX1_IR : ST_SH_IR;
         end
         // [R17] shift-ir loop
         ST_SH_IR: begin
            nxt = tms_v ? ST_EX1_IR : ST_SH_IR;
         end
         // [R19] exit1-ir branch
         ST_EX1_IR: begin
            nxt = tms_v ? ST_UPD_IR : ST_PAU_IR;
         end
         // [R20] pause-ir hold
         ST_PAU_IR: begin
            nxt = tms_v ? ST_EX2_IR : ST_PAU_IR;
         end
         // [R21] exit2-ir branch
         ST_EX2_IR: begin
            nxt = tms_v ? ST_UPD_IR : ST_SH_IR;
         end
         // [R23] update-ir exit
         ST_UPD_IR: begin
            nxt = tms_v ? ST_SEL_DR : ST_IDLE;
         end
         // an illegal code falls back to reset, so the machine self-heals
         default: begin
            nxt = ST_TLR;
         end
      endcase
      return nxt;
   endfunction

   // tck, tms and tdi come from the tester's domain
   // the pipe adds two clk of latency to every pin edge
   jtap_sync #(
      .W    (3)
   ) u_sync (
      .clk  (clk),
      .srst (srst),
      .din  ({tck, tms, tdi}),
      .dout (pins_s)
   );

   assign tck_s = pins_s[2];
   assign tms_s = pins_s[1];
   assign tdi_s = pins_s[0];

   // edge detection on the synchronised tck; tms and tdi share its
   // delay, so they are sampled with the same alignment as at the pins
   // limitation: each tck half must last several clk cycles, so that
   // tms and tdi are settled when the rise is seen
   // tck is taken as parked low at power-up; a tester that parks it
   // high sees one extra rise just after reset
   assign tck_rise = tck_s & ~st_ff.tck_d;
   assign tck_fall = ~tck_s & st_ff.tck_d;

   // state decodes from the registered state
   assign in_tlr    = (st_ff.state == ST_TLR);
   assign in_cap_dr = (st_ff.state == ST_CAP_DR);
   assign in_sh_dr  = (st_ff.state == ST_SH_DR);
   assign in_upd_dr = (st_ff.state == ST_UPD_DR);
   assign in_cap_ir = (st_ff.state == ST_CAP_IR);
   assign in_sh_ir  = (st_ff.state == ST_SH_IR);
   assign in_upd_ir = (st_ff.state == ST_UPD_IR);

   // selection follows the latched instruction, never the shifter
   // opcodes with no register of their own fall to the bypass bit
   assign sel_bsr = (ir_preg == OP_EXTEST) | (ir_preg == OP_SAMPLE);
   assign sel_id  = (ir_preg == OP_IDCODE);
   assign sel_byp = ~sel_bsr & ~sel_id;

   // instruction register; shifter and latch are kept apart so a
   // partial scan never disturbs the instruction in force
   jtap_shreg #(
      .W       (IR_LEN),
      .RST_VAL (OP_IDCODE)
   ) u_ir (
      .clk     (clk),
      .srst    (srst),
      // [R15] fixed capture pattern
      .capture (tck_rise & in_cap_ir),
      .cap_val (IR_CAPTURE),
      // [R17] shift toward tdo
      .shift   (tck_rise & in_sh_ir),
      .sin     (tdi_s),
      // [R22] latch on tck fall
      .update  (tck_fall & in_upd_ir),
      // [R03] idcode while in reset
      .init    (in_tlr),
      .sreg    (ir_sreg),
      .preg    (ir_preg)
   );

   // boundary register; pin_in is core-side logic on clk
   // pin_in is not synchronised, so the core must hold it steady
   // across each capture
   jtap_shreg #(
      .W       (BSR_LEN),
      .RST_VAL ('0)
   ) u_bsr (
      .clk     (clk),
      .srst    (srst),
      // [R07] capture pins for extest or sample
      .capture (tck_rise & in_cap_dr & sel_bsr),
      .cap_val (pin_in),
      // [R09] shift when selected
      .shift   (tck_rise & in_sh_dr & sel_bsr),
      .sin     (tdi_s),
      // [R13] update on tck fall only
      .update  (tck_fall & in_upd_dr & sel_bsr),
      .init    (1'b0),
      .sreg    (bsr_sreg),
      .preg    (bsr_out)
   );

   // identification register, no parallel output is needed
   // no init: the shifter is always reloaded in capture-dr first
   jtap_shreg #(
      .W       (ID_LEN),
      .RST_VAL ('0)
   ) u_id (
      .clk     (clk),
      .srst    (srst),
      .capture (tck_rise & in_cap_dr & sel_id),
      .cap_val (ID_VALUE),
      // [R09] shift when selected
      .shift   (tck_rise & in_sh_dr & sel_id),
      .sin     (tdi_s),
      .update  (1'b0),
      .init    (1'b0),
      .sreg    (id_sreg),
      .preg    ()
   );

   // serial output mux: ir in shift-ir, else the selected data register
   // sampled only at tck falls, so a change between falls is harmless
   always_comb begin
      if (in_sh_ir) begin
         scan_out = ir_sreg[0];
      end else if (sel_bsr) begin
         scan_out = bsr_sreg[0];
      end else if (sel_id) begin
         scan_out = id_sreg[0];
      end else begin
         scan_out = st_ff.bypass;
      end
   end

   // controller next state
   always_comb begin
      nxt_st       = st_ff;
      nxt_st.tck_d = tck_s;

      // [R01] advance on tck rise
      if (tck_rise) begin
         nxt_st.state = tap_next(st_ff.state, tms_s);
      end

      // bypass bit: zero on capture, tdi on shift, else it holds
      // [R18] unselected registers hold
      if (tck_rise & in_cap_dr & sel_byp) begin
         nxt_st.bypass = 1'b0;
      end else if (tck_rise & in_sh_dr & sel_byp) begin
         nxt_st.bypass = tdi_s;
      end

      // oe is refreshed on falls only, so it lags the state by half a tck
      // [R24] tdo changes only on tck fall
      if (tck_fall) begin
         nxt_st.tdo_oe = in_sh_dr | in_sh_ir;
         nxt_st.tdo    = (in_sh_dr | in_sh_ir) ? scan_out : 1'b0;
      end

      // taken from the next state so the drive drops in the very cycle
      // that the controller lands in test-logic-reset
      // [R03] test logic off in reset
      nxt_st.extest = (nxt_st.state != ST_TLR) &
                      (ir_preg == OP_EXTEST);
   end

   // state register; srst stands for power-up
   always_ff @(posedge clk) begin
      // [R04] reset to test-logic-reset
      if (srst) begin
         st_ff.state  <= ST_TLR;
         st_ff.tck_d  <= 1'b0;
         st_ff.bypass <= 1'b0;
         st_ff.tdo    <= 1'b0;
         st_ff.tdo_oe <= 1'b0;
         st_ff.extest <= 1'b0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // outputs from flip-flops; test_reset is a plain decode of the state
   // flop, so it follows the state without lag
   assign tdo          = st_ff.tdo;
   assign tdo_oe       = st_ff.tdo_oe;
   assign extest_drive = st_ff.extest;
   assign test_reset   = in_tlr;
   assign tap_state    = st_ff.state;
   assign cur_instr    = ir_preg;

endmodule

// [hdl/jtap_pkg.sv]
// shared constants and types for the boundary-scan tap controller
package jtap_pkg;

   // instruction register width and the fixed capture pattern
   localparam int          IR_LEN      = 3;
   localparam logic [2:0]  IR_CAPTURE  = 3'h4;

   // opcodes, the values are arbitrary
   localparam logic [2:0]  OP_EXTEST   = 3'h0;
   localparam logic [2:0]  OP_SAMPLE   = 3'h1;
   localparam logic [2:0]  OP_IDCODE   = 3'h2;
   localparam logic [2:0]  OP_BYPASS   = 3'h7;

   // identification register, value is arbitrary
   localparam int          ID_LEN      = 32;
   localparam logic [31:0] ID_DEFAULT  = 32'h0000_1001;

   // boundary register length and the reset-by-tms edge count
   localparam int          BSR_LEN_DEF = 8;
   localparam int          TLR_EDGES   = 5;

   // controller states
   typedef enum logic [3:0] {
      ST_TLR     = 4'h0,
      ST_IDLE    = 4'h1,
      ST_SEL_DR  = 4'h2,
      ST_CAP_DR  = 4'h3,
      ST_SH_DR   = 4'h4,
      ST_EX1_DR  = 4'h5,
      ST_PAU_DR  = 4'h6,
      ST_EX2_DR  = 4'h7,
      ST_UPD_DR  = 4'h8,
      ST_SEL_IR  = 4'h9,
      ST_CAP_IR  = 4'ha,
      ST_SH_IR   = 4'hb,
      ST_EX1_IR  = 4'hc,
      ST_PAU_IR  = 4'hd,
      ST_EX2_IR  = 4'he,
      ST_UPD_IR  = 4'hf
   } jtap_state_e;

endpackage

// [hdl/jtap_sync.sv]
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
module jtap_sync
   import jtap_pkg::*;
#(
   parameter int W = 3
) (
   input  wire logic         clk,
   input  wire logic         srst,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stab;
   } jtap_sync_s;

   jtap_sync_s st_ff;
   jtap_sync_s nxt_st;

   // first stage feeds only the second stage
   always_comb begin
      nxt_st      = st_ff;
      nxt_st.meta = din;
      nxt_st.stab = st_ff.meta;
   end

   // state register
   always_ff @(posedge clk) begin
      if (srst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign dout = st_ff.stab;

endmodule

// [hdl/jtap_shreg.sv]
// scan shift register with capture, shift and latched parallel output
`timescale 1ns/10ps
module jtap_shreg
   import jtap_pkg::*;
#(
   parameter int           W       = 3,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         clk,
   input  wire logic         srst,
   input  wire logic         capture,
   input  wire logic [W-1:0] cap_val,
   input  wire logic         shift,
   input  wire logic         sin,
   input  wire logic         update,
   input  wire logic         init,
   output logic      [W-1:0] sreg,
   output logic      [W-1:0] preg
);

   typedef struct packed {
      logic [W-1:0] sr;
      logic [W-1:0] pr;
   } jtap_shreg_s;

   jtap_shreg_s st_ff;
   jtap_shreg_s nxt_st;

   // shift path moves toward bit 0, which is the serial output
   always_comb begin
      nxt_st = st_ff;
      if (capture) begin
         nxt_st.sr = cap_val;
      end else if (shift) begin
         if (W > 1) begin
            nxt_st.sr = {sin, st_ff.sr[W-1:1]};
         end else begin
            nxt_st.sr = {W{sin}};
         end
      end
      // parallel side holds unless explicitly updated or initialised
      if (init) begin
         nxt_st.pr = RST_VAL;
      end else if (update) begin
         nxt_st.pr = st_ff.sr;
      end
   end

   // state register
   always_ff @(posedge clk) begin
      if (srst) begin
         st_ff.sr <= '0;
         st_ff.pr <= RST_VAL;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign sreg = st_ff.sr;
   assign preg = st_ff.pr;

endmodule

// [testbench/jtap_tap_ctrl_assertions.sv]
// port-level checker for the tap controller, bound into the design
`timescale 1ns/10ps
module jtap_chk
   import jtap_pkg::*;
#(
   parameter int BSR_LEN = BSR_LEN_DEF
) (
   input  wire logic               clk,
   input  wire logic               srst,
   input  wire logic               tck,
   input  wire logic               tms,
   input  wire logic               tdi,
   input  wire logic [BSR_LEN-1:0] pin_in,
   input  wire logic               tdo,
   input  wire logic               tdo_oe,
   input  wire logic [BSR_LEN-1:0] bsr_out,
   input  wire logic               extest_drive,
   input  wire logic               test_reset,
   input  wire logic [3:0]         tap_state,
   input  wire logic [2:0]         cur_instr
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   tlr_after_rst_a:
      assert property ($fell(srst) |-> tap_state == ST_TLR)
      else $error("state not test-logic-reset after reset");
   reset_flag_a:
      assert property (test_reset == (tap_state == ST_TLR))
      else $error("test_reset disagrees with state");
   tlr_idcode_a:
      assert property ((tap_state == ST_TLR) [*2] |-> cur_instr == OP_IDCODE)
      else $error("instruction not idcode in reset state");
   // a move needs a tck rise some clocks back, after a low stretch
   rise_paced_a:
      assert property ($changed(tap_state) |-> $past(tck, 2) && !$past(tck, 6))
      else $error("state moved without a tck rise");
   idle_exit_a:
      assert property ((tap_state == ST_IDLE) ##1 (tap_state != ST_IDLE)
                       |-> tap_state == ST_SEL_DR)
      else $error("idle left to wrong state");
   sel_ir_exit_a:
      assert property ((tap_state == ST_SEL_IR) ##1 (tap_state != ST_SEL_IR)
                       |-> tap_state inside {ST_CAP_IR, ST_TLR})
      else $error("select-ir left to wrong state");
   ex1_dr_exit_a:
      assert property ((tap_state == ST_EX1_DR) ##1 (tap_state != ST_EX1_DR)
                       |-> tap_state inside {ST_UPD_DR, ST_PAU_DR})
      else $error("exit1-dr left to wrong state");
   pause_dr_exit_a:
      assert property ((tap_state == ST_PAU_DR) ##1 (tap_state != ST_PAU_DR)
                       |-> tap_state == ST_EX2_DR)
      else $error("pause-dr left to wrong state");
   instr_hold_a:
      assert property ($changed(cur_instr)
                       |-> $past(tap_state) inside {ST_UPD_IR, ST_TLR})
      else $error("instruction changed outside update-ir");
   bsr_hold_a:
      assert property ($changed(bsr_out)
                       |-> $past(tap_state) == ST_UPD_DR && !$past(tck, 1))
      else $error("boundary output changed outside update-dr fall");
   oe_in_shift_a:
      assert property ($rose(tdo_oe)
                       |-> tap_state inside {ST_SH_DR, ST_SH_IR} && !tck)
      else $error("tdo enabled outside a shift state");
   tdo_quiet_a:
      assert property (!tdo_oe |-> !tdo)
      else $error("tdo active while not driven");
   extest_off_a:
      assert property (test_reset |-> !extest_drive)
      else $error("extest drive active in reset state");

   // main scenarios reached
   cover property (tap_state == ST_PAU_DR);
   cover property (tap_state == ST_UPD_IR);
   cover property ($rose(tdo_oe));
endmodule

bind jtap_tap_ctrl jtap_chk #(.BSR_LEN(BSR_LEN)) u_chk (
   .clk          (clk),
   .srst         (srst),
   .tck          (tck),
   .tms          (tms),
   .tdi          (tdi),
   .pin_in       (pin_in),
   .tdo          (tdo),
   .tdo_oe       (tdo_oe),
   .bsr_out      (bsr_out),
   .extest_drive (extest_drive),
   .test_reset   (test_reset),
   .tap_state    (tap_state),
   .cur_instr    (cur_instr)
);

// [testbench/jtap_tester.sv]
// boundary-scan tester model: drives tck, tms and tdi one bit at a time
`timescale 1ns/10ps
module jtap_tester (
   input  wire logic clk,
   output logic      tck,
   output logic      tms,
   output logic      tdi
);
   // tck rests low outside bits so no stray edge is seen
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end

   // low half: tms and tdi change with the fall, stable over the rise
   task automatic low_half(input logic m, input logic d);
      tms = m;
      tdi = d;
      repeat (8) @(negedge clk);
   endtask

   // high half of a 64 ns period, ends with the fall
   task automatic high_half();
      tck = 1'b1;
      repeat (8) @(negedge clk);
      tck = 1'b0;
   endtask
endmodule

// [testbench/test_jtag_tap_controller.sv]
// self-checking bench: tap controller against a behavioural model
`timescale 1ns/10ps
module test_jtag_tap_controller
   import jtap_pkg::*;
;
   logic        clk, srst, tck, tms, tdi, tdo, tdo_oe, extest_drive;
   logic        test_reset;
   logic [7:0]  pin_in, bsr_out;
   logic [3:0]  tap_state;
   logic [2:0]  cur_instr;
   logic [63:0] dr;
   int          miscompares, total_checks, seed, s, ir, cur, dlen, bo;
   int          k, j;
   logic [2:0]  ops[4] = '{OP_EXTEST, OP_SAMPLE, OP_IDCODE, OP_BYPASS};
   // next state for tms low and tms high, in state-code order
   int nxt0[16] = '{1, 1, 3, 4, 4, 6, 6, 4, 1, 10, 11, 11, 13, 13, 11, 1};
   int nxt1[16] = '{0, 2, 9, 5, 5, 8, 7, 8, 2, 0, 12, 12, 15, 14, 15, 2};

   jtap_tap_ctrl DUT (
      .clk          (clk),
      .srst         (srst),
      .tck          (tck),
      .tms          (tms),
      .tdi          (tdi),
      .pin_in       (pin_in),
      .tdo          (tdo),
      .tdo_oe       (tdo_oe),
      .bsr_out      (bsr_out),
      .extest_drive (extest_drive),
      .test_reset   (test_reset),
      .tap_state    (tap_state),
      .cur_instr    (cur_instr)
   );

   jtap_tester u_tst (
      .clk (clk),
      .tck (tck),
      .tms (tms),
      .tdi (tdi)
   );

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic check(input string what, input logic [63:0] seen,
                        input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("FAIL %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // power-up stand-in; model returns to reset state too
   task automatic do_reset();
      srst = 1'b1;
      repeat (6) @(negedge clk);
      srst = 1'b0;
      s = ST_TLR;
      cur = OP_IDCODE;
      bo = 0;
   endtask

   // one tck bit: outputs from the last fall, then the rise and the fall
   task automatic step(input logic m, input logic d);
      logic exp_tdo;
      pin_in = 8'($random(seed));
      u_tst.low_half(m, d);
      check("tdo_oe", tdo_oe, s == ST_SH_DR || s == ST_SH_IR);
      exp_tdo = s == ST_SH_IR ? ir[0] : s == ST_SH_DR ? dr[0] : 1'b0;
      check("tdo", tdo, exp_tdo);
      check("cur_instr", cur_instr, cur);
      check("bsr_out", bsr_out, bo);
      check("extest", extest_drive, cur == OP_EXTEST && s != ST_TLR);
      u_tst.high_half();
      case (s)
         ST_CAP_IR: ir = IR_CAPTURE;
         ST_SH_IR:  ir = (ir >> 1) | (int'(d) << 2);
         ST_CAP_DR: begin
            dlen = (cur == OP_EXTEST || cur == OP_SAMPLE) ? 8 :
                   (cur == OP_IDCODE) ? 32 : 1;
            dr = dlen == 8 ? 64'(pin_in) : dlen == 32 ? 64'(ID_DEFAULT) : 0;
         end
         ST_SH_DR:  dr = (dr >> 1) | (64'(d) << (dlen - 1));
         default:   ;
      endcase
      s = m ? nxt1[s] : nxt0[s];
      check("tap_state", tap_state, s);
      check("test_reset", test_reset, s == ST_TLR);
      if (s == ST_UPD_IR)
         cur = ir;
      if (s == ST_UPD_DR && (cur == OP_EXTEST || cur == OP_SAMPLE))
         bo = dr[7:0];
      if (s == ST_TLR)
         cur = OP_IDCODE;
   endtask

   task automatic rstep(input logic m);
      step(m, 1'($random(seed)));
   endtask

   initial begin
      srst = 1'b1;
      pin_in = 8'h00;
      seed = 1;
      miscompares = 0;
      total_checks = 0;
      ir = 0;
      dr = 0;
      dlen = 1;
      do_reset();
      // load each opcode with a pause and exit2 loop
      for (k = 0; k < 4; k++) begin
         rstep(0); rstep(1); rstep(1); rstep(0); rstep(0);
         step(0, ops[k][0]); step(1, ops[k][1]); rstep(0); rstep(0);
         rstep(1); rstep(0); step(1, ops[k][2]); rstep(1); rstep(0);
         // data scan under the new instruction
         rstep(1); rstep(0); rstep(0);
         for (j = 0; j < 40; j++)
            rstep(j == 39);
         rstep(0); rstep(1); rstep(0); rstep(1); rstep(1); rstep(0);
      end
      // random walk over every transition
      repeat (300)
         rstep(1'($random(seed)));
      // six high tms rises from wherever
      repeat (8) begin
         repeat (3) rstep(1'($random(seed)));
         repeat (6) rstep(1);
      end
      // reset in mid shift
      rstep(0); rstep(1); rstep(0); rstep(0); rstep(0);
      do_reset();
      rstep(0);
      rstep(0);
      print_verdict();
   end

   // hang guard
   initial begin
      repeat (100000) @(posedge clk);
      miscompares++;
      print_verdict();
   end
endmodule
